// File: hdl/fpci_map.vh
// fpci_map.vh: constants of the flash protect/command host controller
// assumes: included by the fpci design files, the checker and the bench, clock at FPCI_CLK_MHZ
`ifndef FPCI_MAP_VH
`define FPCI_MAP_VH
// ------------------------------------------------------------
// clock and times
// ------------------------------------------------------------
`define FPCI_CLK_MHZ 10
`define FPCI_T_WP_NS 100
`define FPCI_T_ACC_NS 70
`define FPCI_T_PROT_US 100
`define FPCI_T_UNPROT_MS 10
// least times, rounded up to whole cycles
`define FPCI_WP_CYC ((`FPCI_T_WP_NS * `FPCI_CLK_MHZ + 999) / 1000)
`define FPCI_ACC_CYC ((`FPCI_T_ACC_NS * `FPCI_CLK_MHZ + 999) / 1000)
`define FPCI_PROT_CYC (`FPCI_T_PROT_US * `FPCI_CLK_MHZ)
`define FPCI_UNPROT_CYC (`FPCI_T_UNPROT_MS * 1000 * `FPCI_CLK_MHZ)
// ------------------------------------------------------------
// user operations
// ------------------------------------------------------------
`define FPCI_OP_READ 3'h0
`define FPCI_OP_RESET 3'h1
`define FPCI_OP_AUTOSEL 3'h2
`define FPCI_OP_PROGRAM 3'h3
`define FPCI_OP_BERASE 3'h4
`define FPCI_OP_CERASE 3'h5
`define FPCI_OP_UNPROT 3'h6
// ------------------------------------------------------------
// unlock addresses (17-bit byte address in byte mode, word address else)
// ------------------------------------------------------------
`define FPCI_UNLK1_B 17'h0aaaa
`define FPCI_UNLK2_B 17'h05555
`define FPCI_UNLK1_W 17'h05555
`define FPCI_UNLK2_W 17'h02aaa
// ------------------------------------------------------------
// command data
// ------------------------------------------------------------
`define FPCI_D_UNLK1 8'haa
`define FPCI_D_UNLK2 8'h55
`define FPCI_D_RESET 8'hf0
`define FPCI_D_AUTOSEL 8'h90
`define FPCI_D_PROGRAM 8'ha0
`define FPCI_D_SETUP_ER 8'h80
`define FPCI_D_BLK_ER 8'h30
`define FPCI_D_CHIP_ER 8'h10
// ------------------------------------------------------------
// protection addressing
// ------------------------------------------------------------
`define FPCI_BLK_LSB 12
`define FPCI_BLK_LAST 4'hf
`define FPCI_UNP_ADDR 16'h9000
`define FPCI_VER_BITS 16'h0042
`endif

// File: hdl/fpci_cyc.v
// fpci_cyc: one asynchronous flash bus cycle, read or write, built from clock counts
// assumes: inputs are sampled on start; the caller holds off start until done
`timescale 1ns/1ps
`include "fpci_map.vh"
module fpci_cyc (
   input wire clock,
   input wire sys_rst,
   input wire start,
   input wire wr,
   input wire hold_ce,
   input wire byte_mode,
   input wire [16:0] addr_in,
   input wire [15:0] wdata,
   input wire [16:0] pulse_cyc,
   input wire [15:0] dq_i,
   output reg ce_n,
   output reg oe_n,
   output reg we_n,
   output reg [15:0] addr_o,
   output reg [15:0] dq_o,
   output reg [15:0] dq_oe,
   output reg [15:0] rdata,
   output reg done
);
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam C_IDLE = 3'h0;
   localparam C_SET = 3'h1;
   localparam C_STB = 3'h2;
   localparam C_ACT = 3'h3;
   localparam C_REC = 3'h4;
   localparam C_END = 3'h5;
   reg [2:0] st_q;
   reg [16:0] cnt_q;
   reg wr_q;
   reg hold_q;
   reg byte_q;
   always @(posedge clock) begin
      if (sys_rst) begin
         st_q <= C_IDLE;
         cnt_q <= 17'h00000;
         wr_q <= 1'b0;
         hold_q <= 1'b0;
         byte_q <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         addr_o <= 16'h0000;
         dq_o <= 16'h0000;
         dq_oe <= 16'h0000;
         rdata <= 16'h0000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_q)
            C_IDLE: begin
               if (start) begin
                  wr_q <= wr;
                  hold_q <= hold_ce;
                  byte_q <= byte_mode;
                  cnt_q <= pulse_cyc - 17'h00001;
                  // address settles before any enable falls
                  if (byte_mode) begin
                     addr_o <= addr_in[16:1];
                     dq_o <= {addr_in[0], 7'h00, wdata[7:0]};
                     dq_oe <= {1'b1, 7'h00, {8{wr}}};
                  end else begin
                     addr_o <= addr_in[15:0];
                     dq_o <= wdata;
                     dq_oe <= {16{wr}};
                  end
                  st_q <= C_SET;
               end
            end
            C_SET: begin
               // a high-voltage chip enable must never see a low pulse
               ce_n <= hold_q;
               st_q <= C_STB;
            end
            C_STB: begin
               if (wr_q) begin
                  we_n <= 1'b0;
               end else begin
                  oe_n <= 1'b0; // data lines already released
               end
               st_q <= C_ACT;
            end
            C_ACT: begin
               if (cnt_q == 17'h00000) begin
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  if (!wr_q) begin
                     rdata <= byte_q ? {8'h00, dq_i[7:0]} : dq_i;
                  end
                  st_q <= C_REC;
               end else begin
                  cnt_q <= cnt_q - 17'h00001;
               end
            end
            C_REC: begin
               // data still driven past the rising write enable
               ce_n <= 1'b1;
               st_q <= C_END;
            end
            C_END: begin
               dq_oe <= 16'h0000;
               done <= 1'b1;
               st_q <= C_IDLE;
            end
            default: begin
               st_q <= C_IDLE;
            end
         endcase
      end
   end
endmodule // fpci_cyc

// File: hdl/fpci_host.v
// fpci_host: host controller for a parallel flash with block protection
// assumes: one command at a time on the cmd port; flash pins resolved by the bench
//
// Overview of operation
// - write: enables low, address first, data held
// - host holds reset high voltage whole instruction
// - protect every block before permanent unprotect
// - unprotect: sig line, oe, ce high voltage
// - verify unprotection block by block
// - block number on the four block lines
// - instructions take one to six cycles
// - two coded unlock writes open instructions except read and reset
// - erase confirm preceded by second unlock pair
// - host writes instruction cycles in strict order
`timescale 1ns/1ps
`include "fpci_map.vh"
module fpci_host #(
   parameter [16:0] UNPROT_CYC = `FPCI_UNPROT_CYC
) (
   input wire clock,
   input wire sys_rst,
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire [16:0] cmd_addr,
   input wire [15:0] cmd_wdata,
   input wire byte_sel,
   input wire temp_unprot_req,
   output reg cmd_ready,
   output reg rsp_valid,
   output reg [15:0] rsp_data,
   output reg rsp_fail,
   output wire flash_ce_n,
   output wire flash_oe_n,
   output wire flash_we_n,
   output wire [15:0] flash_addr,
   output wire [15:0] flash_dq_o,
   output wire [15:0] flash_dq_oe,
   input wire [15:0] flash_dq_i,
   output reg width_select,
   output reg reset_unprotect_n,
   output reg rst_hv,
   output reg sig_hv,
   output reg oe_hv,
   output reg ce_hv
);
   // ------------------------------------------------------------
   // states and step decoding
   // ------------------------------------------------------------
   localparam M_IDLE = 3'h0;
   localparam M_LAUNCH = 3'h1;
   localparam M_WAIT = 3'h2;
   localparam M_ULAUNCH = 3'h3;
   localparam M_UWAIT = 3'h4;
   localparam PH_PROT = 2'h0;
   localparam PH_UNP = 2'h1;
   localparam PH_VER = 2'h2;
   localparam [16:0] WP_CYC = `FPCI_WP_CYC;
   localparam [16:0] ACC_CYC = `FPCI_ACC_CYC;
   localparam [16:0] PROT_CYC = `FPCI_PROT_CYC;
   // step word: {last, wr, addr select[1:0], user data, data[7:0]}
   // addr select: 0 user address, 1 first unlock, 2 second unlock
   function [12:0] fpci_step;
      input [2:0] op;
      input [2:0] idx;
      begin
         case ({op, idx})
            {`FPCI_OP_READ, 3'd0}: fpci_step = {2'b10, 2'd0, 1'b0, 8'h00};
            {`FPCI_OP_RESET, 3'd0}: fpci_step = {2'b11, 2'd1, 1'b0, `FPCI_D_RESET};
            {`FPCI_OP_AUTOSEL, 3'd0}, {`FPCI_OP_PROGRAM, 3'd0}, {`FPCI_OP_BERASE, 3'd0},
            {`FPCI_OP_CERASE, 3'd0}, {`FPCI_OP_BERASE, 3'd3}, {`FPCI_OP_CERASE, 3'd3}:
               fpci_step = {2'b01, 2'd1, 1'b0, `FPCI_D_UNLK1};
            {`FPCI_OP_AUTOSEL, 3'd1}, {`FPCI_OP_PROGRAM, 3'd1}, {`FPCI_OP_BERASE, 3'd1},
            {`FPCI_OP_CERASE, 3'd1}, {`FPCI_OP_BERASE, 3'd4}, {`FPCI_OP_CERASE, 3'd4}:
               fpci_step = {2'b01, 2'd2, 1'b0, `FPCI_D_UNLK2};
            {`FPCI_OP_AUTOSEL, 3'd2}: fpci_step = {2'b11, 2'd1, 1'b0, `FPCI_D_AUTOSEL};
            {`FPCI_OP_PROGRAM, 3'd2}: fpci_step = {2'b01, 2'd1, 1'b0, `FPCI_D_PROGRAM};
            {`FPCI_OP_PROGRAM, 3'd3}: fpci_step = {2'b11, 2'd0, 1'b1, 8'h00};
            {`FPCI_OP_BERASE, 3'd2}, {`FPCI_OP_CERASE, 3'd2}:
               fpci_step = {2'b01, 2'd1, 1'b0, `FPCI_D_SETUP_ER};
            {`FPCI_OP_BERASE, 3'd5}: fpci_step = {2'b11, 2'd0, 1'b0, `FPCI_D_BLK_ER};
            {`FPCI_OP_CERASE, 3'd5}: fpci_step = {2'b11, 2'd1, 1'b0, `FPCI_D_CHIP_ER};
            default: fpci_step = {2'b10, 2'd0, 1'b0, 8'h00};
         endcase
      end
   endfunction
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [2:0] st_q;
   reg [2:0] op_q;
   reg [2:0] idx_q;
   reg [16:0] addr_q;
   reg [15:0] data_q;
   reg [1:0] ph_q;
   reg [3:0] blk_q;
   reg start_q;
   wire cyc_done;
   wire [15:0] cyc_rdata;
   wire [12:0] step = fpci_step(op_q, idx_q);
   // ------------------------------------------------------------
   // cycle parameters
   // ------------------------------------------------------------
   reg [16:0] c_addr;
   reg [15:0] c_wdata;
   reg [16:0] c_pulse;
   reg c_wr;
   reg c_hold;
   always @* begin
      c_wdata = 16'h0000;
      c_hold = 1'b0;
      if (st_q == M_ULAUNCH || st_q == M_UWAIT) begin
         c_wr = (ph_q != PH_VER);
         c_pulse = (ph_q == PH_PROT) ? PROT_CYC : (ph_q == PH_UNP) ? UNPROT_CYC : ACC_CYC;
         c_hold = (ph_q == PH_UNP);
         // block number on the block lines in protect and verify, byte lsb held low
         case (ph_q)
            PH_PROT: c_addr = {blk_q, 12'h000, 1'b0};
            PH_UNP: c_addr = {`FPCI_UNP_ADDR, 1'b0};
            default: c_addr = {blk_q, 12'h000, 1'b0} | {`FPCI_VER_BITS, 1'b0};
         endcase
         if (!width_select) begin
            c_addr = c_addr;
         end else begin
            c_addr = {1'b0, c_addr[16:1]};
         end
      end else begin
         c_wr = step[11];
         c_pulse = step[11] ? WP_CYC : ACC_CYC;
         c_wdata = step[8] ? data_q : {8'h00, step[7:0]};
         case (step[10:9])
            2'd1: c_addr = width_select ? `FPCI_UNLK1_W : `FPCI_UNLK1_B;
            2'd2: c_addr = width_select ? `FPCI_UNLK2_W : `FPCI_UNLK2_B;
            default: c_addr = addr_q;
         endcase
      end
   end
   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         st_q <= M_IDLE;
         op_q <= `FPCI_OP_READ;
         idx_q <= 3'h0;
         addr_q <= 17'h00000;
         data_q <= 16'h0000;
         ph_q <= PH_PROT;
         blk_q <= 4'h0;
         start_q <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
         rsp_fail <= 1'b0;
         width_select <= 1'b1;
         reset_unprotect_n <= 1'b0;
         rst_hv <= 1'b0;
         sig_hv <= 1'b0;
         oe_hv <= 1'b0;
         ce_hv <= 1'b0;
      end else begin
         start_q <= 1'b0;
         rsp_valid <= 1'b0;
         reset_unprotect_n <= 1'b1;
         case (st_q)
            M_IDLE: begin
               cmd_ready <= 1'b1;
               // mode and temporary unprotect only move between instructions
               width_select <= ~byte_sel;
               rst_hv <= temp_unprot_req;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  op_q <= cmd_op;
                  addr_q <= cmd_addr;
                  data_q <= cmd_wdata;
                  idx_q <= 3'h0;
                  rsp_fail <= 1'b0;
                  if (cmd_op == `FPCI_OP_UNPROT) begin
                     ph_q <= PH_PROT;
                     blk_q <= 4'h0;
                     sig_hv <= 1'b1;
                     oe_hv <= 1'b1;
                     st_q <= M_ULAUNCH;
                  end else begin
                     st_q <= M_LAUNCH;
                  end
               end
            end
            M_LAUNCH: begin
               start_q <= 1'b1;
               st_q <= M_WAIT;
            end
            M_WAIT: begin
               if (cyc_done) begin
                  if (step[12]) begin
                     rsp_valid <= 1'b1;
                     rsp_data <= cyc_rdata;
                     st_q <= M_IDLE;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                     st_q <= M_LAUNCH;
                  end
               end
            end
            M_ULAUNCH: begin
               start_q <= 1'b1;
               st_q <= M_UWAIT;
            end
            M_UWAIT: begin
               if (cyc_done) begin
                  st_q <= M_ULAUNCH;
                  blk_q <= blk_q + 4'h1;
                  case (ph_q)
                     PH_PROT: begin
                        if (blk_q == `FPCI_BLK_LAST) begin
                           ph_q <= PH_UNP;
                           ce_hv <= 1'b1;
                        end
                     end
                     PH_UNP: begin
                        ph_q <= PH_VER;
                        ce_hv <= 1'b0;
                        blk_q <= 4'h0;
                     end
                     default: begin
                        // any block not reading 00h marks the pass as failed
                        if (cyc_rdata[7:0] != 8'h00) begin
                           rsp_fail <= 1'b1;
                        end
                        if (blk_q == `FPCI_BLK_LAST) begin
                           sig_hv <= 1'b0;
                           oe_hv <= 1'b0;
                           rsp_valid <= 1'b1;
                           rsp_data <= cyc_rdata;
                           st_q <= M_IDLE;
                        end
                     end
                  endcase
               end
            end
            default: begin
               st_q <= M_IDLE;
            end
         endcase
      end
   end
   // ------------------------------------------------------------
   // bus cycle engine
   // ------------------------------------------------------------
   fpci_cyc u_cyc (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(start_q),
      .wr(c_wr),
      .hold_ce(c_hold),
      .byte_mode(~width_select),
      .addr_in(c_addr),
      .wdata(c_wdata),
      .pulse_cyc(c_pulse),
      .dq_i(flash_dq_i),
      .ce_n(flash_ce_n),
      .oe_n(flash_oe_n),
      .we_n(flash_we_n),
      .addr_o(flash_addr),
      .dq_o(flash_dq_o),
      .dq_oe(flash_dq_oe),
      .rdata(cyc_rdata),
      .done(cyc_done)
   );
endmodule // fpci_host

// File: test/fpci_host_chk.sv
// fpci_host_chk: timing checker for the flash pins and the command port
// assumes: bound to fpci_host, sees its ports only
`timescale 1ns/1ps
`include "fpci_map.vh"
module fpci_host_chk #(
   parameter [16:0] UNPROT_CYC = `FPCI_UNPROT_CYC
) (
   input wire clock,
   input wire sys_rst,
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire cmd_ready,
   input wire rsp_valid,
   input wire flash_ce_n,
   input wire flash_oe_n,
   input wire flash_we_n,
   input wire [15:0] flash_addr,
   input wire [15:0] flash_dq_o,
   input wire [15:0] flash_dq_oe,
   input wire width_select,
   input wire rst_hv,
   input wire sig_hv,
   input wire oe_hv,
   input wire ce_hv
);
   reg [16:0] low_q;
   reg [4:0] npro_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------------------
   // helpers: write pulse length under high voltage, protect pulses
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (sys_rst || flash_we_n || !ce_hv) low_q <= 17'h00000;
      else low_q <= low_q + 17'h00001;
      if (sys_rst || cmd_ready) npro_q <= 5'h00;
      else if ($fell(flash_we_n) && oe_hv && !ce_hv) npro_q <= npro_q + 5'h01;
   end
   a_wr_oe_off: assert property (!flash_we_n |-> flash_oe_n)
      else $error("write strobe with output enable low");
   a_wr_ce_first: assert property ($fell(flash_we_n) && !ce_hv |->
      !flash_ce_n && $past(flash_ce_n) == 1'b0) else $error("chip enable late");
   a_wr_data_held: assert property ($rose(flash_we_n) |-> $stable(flash_dq_o) &&
      $stable(flash_addr) && (ce_hv || !flash_ce_n)) else $error("write data moved");
   a_rd_no_drive: assert property (!flash_oe_n |-> flash_dq_oe[14:0] == 15'h0000)
      else $error("host drives data during read");
   a_byte_mid_float: assert property (!width_select |-> flash_dq_oe[14:8] == 7'h00)
      else $error("middle lines driven in byte mode");
   a_byte_lsb_out: assert property (!width_select && !flash_ce_n |-> flash_dq_oe[15])
      else $error("lowest address bit not driven");
   a_hv_rst_hold: assert property (!cmd_ready && $past(cmd_ready) == 1'b0 |-> $stable(rst_hv))
      else $error("reset pin voltage changed mid command");
   a_unp_armed: assert property ($fell(flash_we_n) && ce_hv |-> sig_hv && oe_hv &&
      flash_addr[15] && flash_addr[12]) else $error("unprotect not armed");
   a_unp_len: assert property ($rose(flash_we_n) && ce_hv |-> low_q == UNPROT_CYC)
      else $error("unprotect pulse length wrong");
   a_all_prot: assert property ($rose(ce_hv) |-> npro_q == 5'h10)
      else $error("not every block protected first");
   a_ver_addr: assert property (!flash_oe_n && sig_hv |-> flash_addr[6] && flash_addr[1] &&
      !flash_addr[0]) else $error("verify address bits wrong");
   a_hv_ce_high: assert property (ce_hv |-> flash_ce_n)
      else $error("chip enable low with high voltage");
   a_rd_latency: assert property (cmd_valid && cmd_ready && cmd_op == `FPCI_OP_READ |->
      ##[7:9] rsp_valid) else $error("read answer late");
   a_pg_cycles: assert property (cmd_valid && cmd_ready && cmd_op == `FPCI_OP_PROGRAM |->
      ##[31:33] rsp_valid) else $error("program length wrong");
endmodule // fpci_host_chk
bind fpci_host fpci_host_chk #(.UNPROT_CYC(UNPROT_CYC)) u_chk (.clock, .sys_rst, .cmd_valid,
   .cmd_op, .cmd_ready, .rsp_valid, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
   .flash_dq_o, .flash_dq_oe, .width_select, .rst_hv, .sig_hv, .oe_hv, .ce_hv);

// File: test/fpci_flash_mdl.sv
// fpci_flash_mdl: behavioural parallel flash with block protection
// assumes: data lines resolved by the bench, high voltage given as qualifiers
`timescale 1ns/1ps
module fpci_flash_mdl #(
   parameter [7:0] MAKER_ID = 8'h5a, // arbitrary
   parameter [7:0] PART_ID = 8'h3c, // arbitrary
   parameter [15:0] PROT_INIT = 16'h8001,
   parameter int UNP_NS = 10000000
) (
   input wire flash_ce_n,
   input wire flash_oe_n,
   input wire flash_we_n,
   input wire [15:0] flash_addr,
   input wire [15:0] dq_bus,
   input wire width_select,
   input wire reset_unprotect_n,
   input wire rst_hv,
   input wire sig_hv,
   input wire oe_hv,
   input wire ce_hv,
   output logic [15:0] mdl_dq,
   output logic [15:0] mdl_en
);
   logic [15:0] mem [0:65535];
   logic [15:0] prot = PROT_INIT;
   logic [16:0] a_q = 17'h00000;
   logic asel = 1'b0;
   logic [7:0] d;
   int st = 0;
   time t0 = 0;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   // rst_hv only bypasses protection, never clears it, so leaving temp mode restores it
   function automatic bit open_blk(input [3:0] b);
      return !prot[b] || rst_hv;
   endfunction
   function automatic bit u1();
      return width_select ? a_q == 17'h05555 : a_q == 17'h0aaaa;
   endfunction
   function automatic bit u2();
      return width_select ? a_q == 17'h02aaa : a_q == 17'h05555;
   endfunction
   task automatic wipe(input bit all, input [3:0] b);
      for (int k = 0; k < 65536; k++)
         if ((all || k[15:12] == b) && open_blk(k[15:12])) mem[k] = 16'hffff;
   endtask
   // ------------------------------------------------------------
   // write side: address at strobe fall, data at strobe rise
   // ------------------------------------------------------------
   always @(negedge flash_we_n) begin
      a_q = width_select ? {1'b0, flash_addr} : {flash_addr, dq_bus[15]};
      t0 = $time;
      if (sig_hv && oe_hv && !ce_hv && !flash_ce_n) prot[flash_addr[15:12]] = 1'b1;
   end
   always @(posedge flash_we_n) begin
      d = dq_bus[7:0];
      if (sig_hv && oe_hv && ce_hv && flash_addr[15] && flash_addr[12] && $time - t0 >= UNP_NS)
         prot = 16'h0000;
      else if (reset_unprotect_n && !flash_ce_n && flash_oe_n && !oe_hv) begin
         asel = 1'b0;
         case (st)
            0, 3: st = (u1() && d == 8'haa) ? st + 1 : 0;
            1, 4: st = (u2() && d == 8'h55) ? st + 1 : 0;
            2: begin
               st = (u1() && d == 8'ha0) ? 6 : (u1() && d == 8'h80) ? 3 : 0;
               asel = u1() && d == 8'h90;
            end
            5: begin
               if (d == 8'h30) wipe(1'b0, a_q[15:12]);
               if (d == 8'h10 && u1()) wipe(1'b1, 4'h0);
               st = 0;
            end
            default: begin
               if (open_blk(a_q[15:12])) mem[a_q[15:0]] = dq_bus;
               st = 0;
            end
         endcase
      end
   end
   always @(negedge reset_unprotect_n) begin
      st = 0;
      asel = 1'b0;
   end
   // ------------------------------------------------------------
   // read side
   // ------------------------------------------------------------
   always_comb begin
      mdl_en = 16'h0000;
      mdl_dq = mem[flash_addr];
      if (!width_select) mdl_dq = {8'h00, dq_bus[15] ? mdl_dq[15:8] : mdl_dq[7:0]};
      if (asel || sig_hv) mdl_dq = flash_addr[1] ? {15'h0000, prot[flash_addr[15:12]]} :
         {8'h00, flash_addr[0] ? PART_ID : MAKER_ID};
      if (reset_unprotect_n && !flash_ce_n && !flash_oe_n)
         mdl_en = width_select ? 16'hffff : 16'h00ff;
   end
endmodule // fpci_flash_mdl

// File: test/test_fpci_host.sv
// test_fpci_host: self-checking bench for the flash host controller
// assumes: flash model on the pins, unprotect time shortened to 20 cycles
`timescale 1ns/1ps
`include "fpci_map.vh"
module test_fpci_host;
   localparam [16:0] UNP = 17'h00014;
   localparam [7:0] MAKER_ID = 8'ha7; // arbitrary
   localparam [7:0] PART_ID = 8'h6b; // arbitrary
   logic clock = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, byte_sel = 1'b0, temp_unprot_req = 1'b0;
   logic [2:0] cmd_op = 3'h0;
   logic [16:0] cmd_addr = 17'h00000, a;
   logic [15:0] cmd_wdata = 16'h0000, junk = 16'h0027, lf = 16'h0027, pm = 16'h8001, e;
   logic [15:0] ref_mem [int];
   logic [16:0] aq [$];
   int n_fail = 0, cmp_count = 0;
   wire cmd_ready, rsp_valid, rsp_fail, flash_ce_n, flash_oe_n, flash_we_n, width_select;
   wire reset_unprotect_n, rst_hv, sig_hv, oe_hv, ce_hv;
   wire [15:0] rsp_data, flash_addr, flash_dq_o, flash_dq_oe, mdl_dq, mdl_en;
   // undriven lines carry a changing pattern so stale values cannot pass
   wire [15:0] dq_bus = (flash_dq_oe & flash_dq_o) | (~flash_dq_oe & mdl_en & mdl_dq) |
      (~flash_dq_oe & ~mdl_en & junk);
   fpci_host #(.UNPROT_CYC(UNP)) DUT (.clock, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr,
      .cmd_wdata, .byte_sel, .temp_unprot_req, .cmd_ready, .rsp_valid, .rsp_data, .rsp_fail,
      .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_o, .flash_dq_oe,
      .flash_dq_i(dq_bus), .width_select, .reset_unprotect_n, .rst_hv, .sig_hv, .oe_hv, .ce_hv);
   fpci_flash_mdl #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .PROT_INIT(16'h8001),
      .UNP_NS(UNP * 100)) mdl (.flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .dq_bus,
      .width_select, .reset_unprotect_n, .rst_hv, .sig_hv, .oe_hv, .ce_hv, .mdl_dq, .mdl_en);
   always #50 clock = ~clock;
   always @(posedge clock) #1 junk = lfsr(junk);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic [15:0] lfsr(input [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic [15:0] rx(input int k);
      return ref_mem.exists(k) ? ref_mem[k] : 16'hffff;
   endfunction
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input [15:0] ex, input [15:0] got);
      cmp_count++;
      if (got !== ex) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
         n_fail++;
      end
   endtask
   // called just after an edge; request held until taken, then waits the answer pulse
   task automatic cmd(input [2:0] op, input [16:0] ad, input [15:0] wd);
      int n;
      n = 0;
      cmd_op = op;
      cmd_addr = ad;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (cmd_ready !== 1'b1 && n < 40000);
      #1;
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 40000) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 40000) begin
         n_fail++;
         summarize();
      end
   endtask
   task automatic rd(input [16:0] ad, input [15:0] ex, input string nm);
      cmd(`FPCI_OP_READ, ad, 16'h0000);
      chk(nm, ex, rsp_data);
   endtask
   task automatic rd_all(input string nm);
      foreach (aq[k]) rd(aq[k], rx(aq[k]), nm);
   endtask
   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic prog(input [16:0] ad, input bit opn);
      lf = lfsr(lf);
      aq.push_back(ad);
      cmd(`FPCI_OP_PROGRAM, ad, lf);
      if (opn) ref_mem[ad] = lf;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      rd(17'h00100, 16'hffff, "blank");
      for (int i = 0; i < 6; i++) begin
         lf = lfsr(lf);
         a = {1'b0, 4'(i * 3), lf[11:0]};
         prog(a, !pm[a[15:12]]);
         rd(a, rx(a), "program");
      end
      temp_unprot_req = 1'b1;
      settle();
      prog(17'h00010, 1'b1);
      prog(17'h0f010, 1'b1);
      temp_unprot_req = 1'b0;
      settle();
      prog(17'h00011, 1'b0);
      rd_all("temporary");
      cmd(`FPCI_OP_BERASE, 17'h0f000, 16'h0000);
      cmd(`FPCI_OP_BERASE, 17'h03000, 16'h0000);
      foreach (ref_mem[k]) if (k[15:12] == 4'h3) ref_mem[k] = 16'hffff;
      rd_all("block erase");
      cmd(`FPCI_OP_CERASE, 17'h00000, 16'h0000);
      foreach (ref_mem[k]) if (!pm[k[15:12]]) ref_mem[k] = 16'hffff;
      rd_all("chip erase");
      cmd(`FPCI_OP_AUTOSEL, 17'h00000, 16'h0000);
      rd(17'h00000, {8'h00, MAKER_ID}, "maker");
      rd(17'h00001, {8'h00, PART_ID}, "part");
      for (int b = 0; b < 16; b++) rd({1'b0, 4'(b), 12'h002}, {15'h0, pm[b]}, "status");
      cmd(`FPCI_OP_RESET, 17'h00000, 16'h0000);
      rd(17'h00010, rx(17'h00010), "array again");
      byte_sel = 1'b1;
      settle();
      cmd(`FPCI_OP_AUTOSEL, 17'h00000, 16'h0000);
      rd(17'h00000, {8'h00, MAKER_ID}, "byte maker");
      rd(17'h00002, {8'h00, PART_ID}, "byte part");
      cmd(`FPCI_OP_RESET, 17'h00000, 16'h0000);
      e = rx(17'h00010);
      rd(17'h00021, {8'h00, e[15:8]}, "byte array");
      byte_sel = 1'b0;
      settle();
      cmd(`FPCI_OP_UNPROT, 17'h00000, 16'h0000);
      chk("verify fail", 16'h0000, {15'h0000, rsp_fail});
      chk("verify data", 16'h0000, rsp_data);
      pm = 16'h0000;
      prog(17'h00030, 1'b1);
      rd(17'h00030, rx(17'h00030), "after unprotect");
      summarize();
   end
endmodule // test_fpci_host
